/* File: core/fsr_regs.vh */
// register offsets, field positions and reset values for the fault and result bank
`ifndef FSR_REGS_VH
`define FSR_REGS_VH

`define FSR_ADDR_W          8
`define FSR_DATA_W          8
`define FSR_ADC_W           14
`define FSR_ADC_CH          8
`define FSR_ADC_SEL_W       3

`define FSR_OFF_FAULT2      8'h06
`define FSR_OFF_RESULT_HI   8'h07
`define FSR_OFF_RESULT_LO   8'h08

`define FSR_BIT_WDOG        7
`define FSR_BIT_HICCUP      6
`define FSR_BIT_CUTOFF      5
`define FSR_BIT_VOUT_OV     4
`define FSR_BIT_LIGHT_LOAD  3
`define FSR_BIT_VBAT_OV     2
`define FSR_BIT_BUS_ERR     1
`define FSR_BIT_DEPLETED    0

`define FSR_LATCH_LO        1
`define FSR_LATCH_HI        6
`define FSR_LATCH_N         6

`define FSR_RST_FAULT2      8'h00
`define FSR_RST_RESULT      8'h00
`define FSR_RST_ADC         14'h0000

`define FSR_HI_FULL_MSB     13
`define FSR_HI_FULL_LSB     6
`define FSR_LO_W            6
`define FSR_NARROW_W        8

// dead-battery threshold and hiccup restart interval, kept for reference only
`define FSR_DEPLETED_MV     3000
`define FSR_HICCUP_RESTART_MS 3000

`endif

/* File: core/fsr_flag.v */
// one latching fault flag with guarded read-to-clear
`timescale 1ns/1ns
module fsr_flag (
   input  wire clk,
   input  wire resetn,
   input  wire set_evt,
   input  wire cause_active,
   input  wire rd_clr,
   output wire flag
);
   reg flag_q;
   reg flag_d;

   // set wins over clear; a clear is dropped while the cause stands
   always @* begin
      flag_d = flag_q;
      if (rd_clr && !cause_active) begin
         flag_d = 1'b0;
      end
      if (set_evt) begin
         flag_d = 1'b1;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag = flag_q;
endmodule // fsr_flag

/* File: core/fsr_bank.v */
// second fault register and conversion result registers of the charger
// What this block does
// - Watchdog enabled and expired sets and holds fault bit 7.
// - Reading never clears bit 7; only service read or disable clears.
// - Reverse-mode hiccup entry latches bit 6.
// - Bit 6 stays set through hiccup; read after leaving hiccup clears.
// - Battery below cutoff level latches bit 5; read clears once above.
// - Output over threshold latches bit 4; read clears once below.
// - Light-load off state latches bit 3; read clears after state left.
// - Reverse-mode battery overvoltage latches bit 2; read clears once below.
// - Bus command or data error sets bit 1.
// - While charging, bit 0 shows live whether battery is below 3V.
// - Result register returns result [7:0] narrow or [13:6] full width.
// - Result comes from the channel picked by the read selection.
// - Next register holds the lower six bits of a full result.
`timescale 1ns/1ns
`include "fsr_regs.vh"
module fsr_bank (
   input  wire                                 clk,
   input  wire                                 resetn,
   // register port of the management bus
   input  wire                                 rd_en,
   input  wire [`FSR_ADDR_W-1:0]               rd_addr,
   output wire [`FSR_DATA_W-1:0]               rd_data,
   output wire                                 rd_valid,
   input  wire                                 wr_en,
   input  wire [`FSR_ADDR_W-1:0]               wr_addr,
   input  wire [`FSR_DATA_W-1:0]               wr_data,
   // watchdog
   input  wire                                 wdog_enable,
   input  wire                                 wdog_expired,
   input  wire                                 wdog_service,
   // reverse-mode converter status levels
   input  wire                                 reverse_mode,
   input  wire                                 hiccup_state,
   input  wire                                 vbat_below_cutoff,
   input  wire                                 vout_above_ov,
   input  wire                                 light_load_off_state,
   input  wire                                 vbat_above_ov,
   // serial bus error pulses
   input  wire                                 bus_cmd_error,
   input  wire                                 bus_data_error,
   // charge status
   input  wire                                 charging,
   input  wire                                 vbat_below_3v,
   // converter results
   input  wire [`FSR_ADC_CH*`FSR_ADC_W-1:0]    adc_ch_data,
   input  wire                                 adc_data_ready,
   input  wire [`FSR_ADC_SEL_W-1:0]            adc_read_select,
   input  wire                                 adc_full_width,
   // live flag view for the interrupt logic elsewhere
   output wire [`FSR_DATA_W-1:0]               fault_status_second
);

   // ---------------------------------------------------------------
   // read decode
   // ---------------------------------------------------------------
   wire rd_fault;
   wire rd_hi;
   wire rd_lo;

   assign rd_fault = rd_en && (rd_addr == `FSR_OFF_FAULT2);
   assign rd_hi    = rd_en && (rd_addr == `FSR_OFF_RESULT_HI);
   assign rd_lo    = rd_en && (rd_addr == `FSR_OFF_RESULT_LO);

   // writes into this bank are accepted on the bus but never land:
   // every bit here is owned by hardware
   wire wr_ignored;
   assign wr_ignored = wr_en && (wr_addr == `FSR_OFF_FAULT2) && (wr_data != wr_data);

   // ---------------------------------------------------------------
   // watchdog flag
   // ---------------------------------------------------------------
   reg wdog_q;
   reg wdog_d;

   always @* begin
      wdog_d = wdog_q;
      // no term here looks at rd_fault: reading leaves the flag alone
      if (wdog_service || !wdog_enable) begin
         wdog_d = 1'b0;
      end
      if (wdog_enable && wdog_expired) begin
         wdog_d = 1'b1;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wdog_q <= 1'b0;
      end else begin
         wdog_q <= wdog_d;
      end
   end

   // ---------------------------------------------------------------
   // latching flags, bits 6 down to 1
   // ---------------------------------------------------------------
   wire [`FSR_LATCH_HI:`FSR_LATCH_LO] set_vec;
   wire [`FSR_LATCH_HI:`FSR_LATCH_LO] cause_vec;
   wire [`FSR_LATCH_HI:`FSR_LATCH_LO] flag_vec;

   // previous hiccup level so that only entry raises the flag; the level
   // itself keeps the flag pinned for the whole restart interval
   reg hiccup_prev_q;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hiccup_prev_q <= 1'b0;
      end else begin
         hiccup_prev_q <= hiccup_state;
      end
   end

   assign set_vec[`FSR_BIT_HICCUP]     = reverse_mode && hiccup_state && !hiccup_prev_q;
   assign cause_vec[`FSR_BIT_HICCUP]   = hiccup_state;

   assign set_vec[`FSR_BIT_CUTOFF]     = vbat_below_cutoff;
   assign cause_vec[`FSR_BIT_CUTOFF]   = vbat_below_cutoff;

   assign set_vec[`FSR_BIT_VOUT_OV]    = vout_above_ov;
   assign cause_vec[`FSR_BIT_VOUT_OV]  = vout_above_ov;

   assign set_vec[`FSR_BIT_LIGHT_LOAD]   = light_load_off_state;
   assign cause_vec[`FSR_BIT_LIGHT_LOAD] = light_load_off_state;

   assign set_vec[`FSR_BIT_VBAT_OV]    = reverse_mode && vbat_above_ov;
   assign cause_vec[`FSR_BIT_VBAT_OV]  = reverse_mode && vbat_above_ov;

   // bus errors are single events, so there is no standing cause
   assign set_vec[`FSR_BIT_BUS_ERR]    = bus_cmd_error || bus_data_error;
   assign cause_vec[`FSR_BIT_BUS_ERR]  = 1'b0;

   genvar gi;
   generate
      for (gi = `FSR_LATCH_LO; gi <= `FSR_LATCH_HI; gi = gi + 1) begin : g_flag
         fsr_flag u_flag (
            .clk          (clk),
            .resetn       (resetn),
            .set_evt      (set_vec[gi]),
            .cause_active (cause_vec[gi]),
            .rd_clr       (rd_fault),
            .flag         (flag_vec[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // live depleted-battery indicator
   // ---------------------------------------------------------------
   reg depleted_q;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         depleted_q <= 1'b0;
      end else begin
         depleted_q <= charging && vbat_below_3v;
      end
   end

   wire [`FSR_DATA_W-1:0] fault_word;
   assign fault_word = {wdog_q, flag_vec, depleted_q};
   assign fault_status_second = fault_word;

   // ---------------------------------------------------------------
   // conversion result: channel select and capture
   // ---------------------------------------------------------------
   wire [`FSR_ADC_W-1:0] ch_word [0:`FSR_ADC_CH-1];

   genvar gc;
   generate
      for (gc = 0; gc < `FSR_ADC_CH; gc = gc + 1) begin : g_ch
         assign ch_word[gc] = adc_ch_data[gc*`FSR_ADC_W +: `FSR_ADC_W];
      end
   endgenerate

   reg [`FSR_ADC_W-1:0] adc_sel_q;

   // sample on data-ready so a half-updated word is never shown
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         adc_sel_q <= `FSR_RST_ADC;
      end else if (adc_data_ready) begin
         adc_sel_q <= ch_word[adc_read_select];
      end
   end

   wire [`FSR_DATA_W-1:0] result_hi;
   wire [`FSR_DATA_W-1:0] result_lo;

   assign result_hi = adc_full_width ?
                      adc_sel_q[`FSR_HI_FULL_MSB:`FSR_HI_FULL_LSB] :
                      adc_sel_q[`FSR_NARROW_W-1:0];

   // lower six bits of the full word; upper two read as zero
   assign result_lo = {2'b00, adc_sel_q[`FSR_LO_W-1:0]};

   // reading the high byte freezes the matching low bits so the
   // second read pairs with the first even if a new result arrives
   reg [`FSR_DATA_W-1:0] lo_hold_q;
   reg                   lo_held_q;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lo_hold_q <= `FSR_RST_RESULT;
         lo_held_q <= 1'b0;
      end else if (rd_hi) begin
         lo_hold_q <= result_lo;
         lo_held_q <= 1'b1;
      end else if (rd_lo) begin
         lo_held_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   reg [`FSR_DATA_W-1:0] rd_data_q;
   reg [`FSR_DATA_W-1:0] rd_data_d;
   reg                   rd_valid_q;

   // the returned fault byte is the value before any clear takes hold
   always @* begin
      rd_data_d = rd_data_q;
      if (rd_fault) begin
         rd_data_d = fault_word;
      end else if (rd_hi) begin
         rd_data_d = result_hi;
      end else if (rd_lo) begin
         rd_data_d = lo_held_q ? lo_hold_q : result_lo;
      end else if (rd_en) begin
         rd_data_d = `FSR_RST_RESULT;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data_q  <= `FSR_RST_FAULT2;
         rd_valid_q <= 1'b0;
      end else begin
         rd_data_q  <= rd_data_d;
         rd_valid_q <= rd_en && !wr_ignored;
      end
   end

   assign rd_data  = rd_data_q;
   assign rd_valid = rd_valid_q;

endmodule // fsr_bank

/* File: bench/fsr_bank_checker.sv */
// concurrent checks on the fault and result bank ports
`timescale 1ns/1ns
module fsr_bank_checker (
   input wire       clk,
   input wire       resetn,
   input wire       rd_en,
   input wire [7:0] rd_addr,
   input wire [7:0] rd_data,
   input wire       rd_valid,
   input wire       wdog_enable,
   input wire       wdog_expired,
   input wire       wdog_service,
   input wire       reverse_mode,
   input wire       hiccup_state,
   input wire       vbat_below_cutoff,
   input wire       vout_above_ov,
   input wire       light_load_off_state,
   input wire       vbat_above_ov,
   input wire       bus_cmd_error,
   input wire       bus_data_error,
   input wire       charging,
   input wire       vbat_below_3v,
   input wire [7:0] fault_status_second
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence s_fault_read;
      rd_en && rd_addr == 8'h06;
   endsequence
   sequence s_answer;
      rd_valid;
   endsequence
   a_read_answer: assert property (rd_en |=> s_answer)
      else $error("read got no answer");
   a_no_stray_valid: assert property (!rd_en |=> !rd_valid)
      else $error("answer without read");
   a_fault_snapshot: assert property (s_fault_read |=> s_answer ##0
      rd_data == $past(fault_status_second)) else $error("fault read wrong");
   a_wdog_set: assert property (wdog_enable && wdog_expired |=> fault_status_second[7])
      else $error("watchdog flag not set");
   a_wdog_kept: assert property (fault_status_second[7] && wdog_enable && !wdog_service
      |=> fault_status_second[7]) else $error("watchdog flag lost");
   a_hiccup_set: assert property ($rose(hiccup_state) && reverse_mode
      |=> fault_status_second[6]) else $error("hiccup flag not set");
   a_hiccup_kept: assert property (fault_status_second[6] && hiccup_state
      |=> fault_status_second[6]) else $error("hiccup flag lost");
   a_cutoff_set: assert property (vbat_below_cutoff |=> fault_status_second[5])
      else $error("cutoff flag not set");
   a_vout_ov_set: assert property (vout_above_ov |=> fault_status_second[4])
      else $error("output ov flag not set");
   a_light_load_set: assert property (light_load_off_state |=> fault_status_second[3])
      else $error("light load flag not set");
   a_vbat_ov_set: assert property (reverse_mode && vbat_above_ov
      |=> fault_status_second[2]) else $error("battery ov flag not set");
   a_bus_err_set: assert property (bus_cmd_error || bus_data_error
      |=> fault_status_second[1]) else $error("bus error flag not set");
   a_depleted_live: assert property (##1 fault_status_second[0]
      == $past(charging && vbat_below_3v)) else $error("depleted bit not live");
endmodule // fsr_bank_checker
bind fsr_bank fsr_bank_checker fsr_bank_checker_inst (.clk, .resetn, .rd_en, .rd_addr,
   .rd_data, .rd_valid, .wdog_enable, .wdog_expired, .wdog_service, .reverse_mode,
   .hiccup_state, .vbat_below_cutoff, .vout_above_ov, .light_load_off_state,
   .vbat_above_ov, .bus_cmd_error, .bus_data_error, .charging, .vbat_below_3v,
   .fault_status_second);

/* File: bench/fsr_host.sv */
// host model issuing single register reads
`timescale 1ns/1ns
module fsr_host (
   input  wire       clk,
   input  wire       resetn,
   input  wire       go,
   input  wire [7:0] addr,
   input  wire [7:0] rd_data,
   input  wire       rd_valid,
   output reg        rd_en,
   output reg  [7:0] rd_addr,
   output wire       wr_en,
   output reg  [7:0] q,
   output reg        done
);
   // the fault bank is read-only, so the host never writes
   assign wr_en = 1'b0;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_en <= 1'b0;
         rd_addr <= 8'h00;
         q <= 8'h00;
         done <= 1'b0;
      end else begin
         rd_en <= go;
         // idle address toggles so a stale value never looks valid
         rd_addr <= go ? addr : ~rd_addr;
         done <= rd_valid;
         if (rd_valid) begin
            q <= rd_data;
         end
      end
   end
endmodule // fsr_host

/* File: bench/fsr_bank_tb.sv */
// self-checking bench for the fault and result register bank
`timescale 1ns/1ns
module fsr_bank_tb;
   reg          clk, resetn, go, wdog_enable, wdog_expired, wdog_service;
   reg          bus_cmd_error, bus_data_error, charging, vbat_below_3v;
   reg          adc_data_ready, adc_full_width, rev;
   reg  [6:2]   cond;
   reg  [2:0]   sel;
   reg  [7:0]   addr;
   reg  [13:0]  w;
   reg  [111:0] adc;
   wire         rd_en, rd_valid, wr_en, done;
   wire [7:0]   rd_addr, rd_data, q, fault;
   integer      fails, n_compared, i, k;
   fsr_bank fsr_bank_inst (.clk, .resetn, .rd_en, .rd_addr, .rd_data, .rd_valid, .wr_en,
      .wr_addr(8'h00), .wr_data(8'h00), .wdog_enable, .wdog_expired, .wdog_service,
      .reverse_mode(rev), .hiccup_state(cond[6]), .vbat_below_cutoff(cond[5]),
      .vout_above_ov(cond[4]), .light_load_off_state(cond[3]), .vbat_above_ov(cond[2]),
      .bus_cmd_error, .bus_data_error, .charging, .vbat_below_3v, .adc_ch_data(adc),
      .adc_data_ready, .adc_read_select(sel), .adc_full_width, .fault_status_second(fault));
   fsr_host fsr_host_inst (.clk, .resetn, .go, .addr, .rd_data, .rd_valid, .rd_en,
      .rd_addr, .wr_en, .q, .done);
   task summarize;
      begin
         if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
   task chk(input [7:0] exp, input [7:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] rd_data exp %h got %h", exp, got);
         end
      end
   endtask
   task rd(input [7:0] a, input [7:0] exp);
      integer t;
      begin
         @(posedge clk) go <= 1'b1;
         addr <= a;
         @(posedge clk) go <= 1'b0;
         t = 0;
         while (t < 8 && done !== 1'b1) begin
            @(posedge clk) #1;
            t = t + 1;
         end
         // judged on done itself, so an answer on the last try still counts
         if (done !== 1'b1) begin
            fails = fails + 1;
            summarize;
         end else begin
            chk(exp, q);
         end
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      {resetn, go, wdog_expired, wdog_service, bus_cmd_error, bus_data_error} = 6'h00;
      {charging, vbat_below_3v, adc_data_ready, adc_full_width} = 4'h0;
      {cond, sel, addr} = 16'h0000;
      wdog_enable = 1'b1;
      rev = 1'b1;
      fails = 0;
      n_compared = 0;
      // distinct word per channel so a wrong selection shows
      for (k = 0; k < 8; k = k + 1) begin
         adc[k*14 +: 14] = 14'h1235 + k * 14'h0457;
      end
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h07, 8'h00);
      @(posedge clk) wdog_expired <= 1'b1;
      @(posedge clk) wdog_expired <= 1'b0;
      rd(8'h06, 8'h80);
      rd(8'h06, 8'h80);
      @(posedge clk) wdog_service <= 1'b1;
      @(posedge clk) wdog_service <= 1'b0;
      rd(8'h06, 8'h00);
      for (i = 2; i < 7; i = i + 1) begin
         @(posedge clk) cond[i] <= 1'b1;
         rd(8'h06, 8'h01 << i);
         rd(8'h06, 8'h01 << i);
         @(posedge clk) cond[i] <= 1'b0;
         rd(8'h06, 8'h01 << i);
         rd(8'h06, 8'h00);
      end
      // outside reverse mode neither hiccup nor battery ov may latch
      @(posedge clk) rev <= 1'b0;
      cond[6] <= 1'b1;
      cond[2] <= 1'b1;
      rd(8'h06, 8'h00);
      @(posedge clk) cond[6] <= 1'b0;
      cond[2] <= 1'b0;
      rev <= 1'b1;
      @(posedge clk) bus_cmd_error <= 1'b1;
      @(posedge clk) bus_cmd_error <= 1'b0;
      rd(8'h06, 8'h02);
      rd(8'h06, 8'h00);
      @(posedge clk) bus_data_error <= 1'b1;
      @(posedge clk) bus_data_error <= 1'b0;
      rd(8'h06, 8'h02);
      @(posedge clk) charging <= 1'b1;
      vbat_below_3v <= 1'b1;
      rd(8'h06, 8'h01);
      rd(8'h06, 8'h01);
      @(posedge clk) vbat_below_3v <= 1'b0;
      rd(8'h06, 8'h00);
      for (k = 0; k < 16; k = k + 1) begin
         w = adc[(k % 8) * 14 +: 14];
         @(posedge clk) sel <= k[2:0];
         adc_full_width <= (k < 8);
         adc_data_ready <= 1'b1;
         @(posedge clk) adc_data_ready <= 1'b0;
         rd(8'h07, (k < 8) ? w[13:6] : w[7:0]);
         rd(8'h08, {2'b00, w[5:0]});
      end
      // a new result between the two reads must not split the pair
      rd(8'h07, w[7:0]);
      @(posedge clk) sel <= 3'h0;
      adc_data_ready <= 1'b1;
      @(posedge clk) adc_data_ready <= 1'b0;
      rd(8'h08, {2'b00, w[5:0]});
      rd(8'h08, {2'b00, adc[5:0]});
      summarize;
   end
endmodule // fsr_bank_tb
